/* File: src/bal_alu.sv */
// Contract
// - Multiply low byte of destination by source byte, 16-bit result.
// - Divide 16-bit destination by source byte: byte quotient, remainder.
// - Compare subtracts register or immediate from destination, no write.
// - Word compare register-to-register only; immediate compare is byte.
// - Negate replaces a byte register with zero minus its value.
// - AND, OR, XOR and complement work on bytes only.
// - AND destination byte with register or immediate, write back.
// - OR destination byte with register or immediate, write back.
// - XOR destination byte with register or immediate, write back.
// - Complement inverts every bit of a byte register in place.
// - Eight one-register byte shifts and rotates.
// - Arithmetic shifts write back to the same register.
// - Logical shifts fill the vacated bit with zero.
// - Rotate through carry uses carry as a ninth bit.
// - Operation in bits 15..8; register forms hold source, destination low.
// - Immediate forms: destination in upper byte, immediate in bits 7..0.
// - General registers are 16 bits; byte results merge into them.
`timescale 1ns/1ps
`default_nettype none
module bal_alu
(
    input  wire logic                        CLK_SYS,
    input  wire logic                        ARST_N,
    input  wire logic                        REQ_VALID,
    output      logic                        REQ_READY,
    input  wire logic [bal_pkg::DATA_W-1:0]  INSTR,
    output      logic [bal_pkg::SEL_W-1:0]   DST_SEL,
    output      logic [bal_pkg::SEL_W-1:0]   SRC_SEL,
    input  wire logic [bal_pkg::DATA_W-1:0]  DST_VALUE,
    input  wire logic [bal_pkg::DATA_W-1:0]  SRC_VALUE,
    input  wire logic                        CARRY_IN,
    output      logic                        DONE,
    output      logic                        ILLEGAL,
    output      logic                        WB_EN,
    output      logic [bal_pkg::SEL_W-1:0]   WB_SEL,
    output      logic [bal_pkg::DATA_W-1:0]  WB_DATA,
    output      logic                        FLAG_WR,
    output      logic                        FLAG_C,
    output      logic                        FLAG_V,
    output      logic                        FLAG_Z,
    output      logic                        FLAG_N
);
    import bal_pkg::*;

    // ==================================================================
    // Byte lane helpers

    function automatic logic [BYTE_W-1:0] get_byte(
        input logic [DATA_W-1:0] w,
        input logic              hi
    );
        get_byte = hi ? w[DATA_W-1:BYTE_W] : w[BYTE_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] put_byte(
        input logic [DATA_W-1:0] w,
        input logic              hi,
        input logic [BYTE_W-1:0] b
    );
        put_byte = hi ? {b, w[BYTE_W-1:0]} : {w[DATA_W-1:BYTE_W], b};
    endfunction

    // ==================================================================
    // State

    bal_state_t          state_r;
    bal_state_t          state_nxt;
    logic [CNT_W-1:0]    cnt_r;
    logic [CNT_W-1:0]    cnt_nxt;
    logic [BYTE_W-1:0]   rem_r;
    logic [BYTE_W-1:0]   rem_nxt;
    logic [BYTE_W-1:0]   quo_r;
    logic [BYTE_W-1:0]   quo_nxt;
    logic [BYTE_W-1:0]   dvs_r;
    logic [BYTE_W-1:0]   dvs_nxt;
    logic                done_r;
    logic                ill_r;
    logic                wr_r;
    logic [SEL_W-1:0]    wsel_r;
    logic [DATA_W-1:0]   data_r;
    logic                flwr_r;
    logic                fc_r;
    logic                fv_r;
    logic                fz_r;
    logic                fn_r;

    // ==================================================================
    // Instruction decode

    wire [OPF_W-1:0]  opf = INSTR[OPF_LSB +: OPF_W];
    wire [IOP_W-1:0]  iop = INSTR[IOP_LSB +: IOP_W];
    wire              is_imm = (iop == IOP_CMP) || (iop == IOP_AND)
                            || (iop == IOP_OR) || (iop == IOP_XOR);
    wire [FLD_W-1:0]  rn = is_imm ? INSTR[IRN_LSB +: FLD_W]
                                  : INSTR[RN_LSB +: FLD_W];
    wire [FLD_W-1:0]  rm = INSTR[RM_LSB +: FLD_W];
    wire [BYTE_W-1:0] imm = INSTR[BYTE_W-1:0];
    wire              hi_d = rn[HIB_POS];
    wire              hi_s = rm[HIB_POS];
    wire [SHK_W-1:0]  shk = INSTR[SHK_LSB +: SHK_W];

    wire op_mul  = (opf == OPC_MUL);
    wire op_div  = (opf == OPC_DIV);
    wire op_cmpw = (opf == OPC_CMPW);
    wire op_cmpb = (opf == OPC_CMPB) || (iop == IOP_CMP);
    wire op_and  = (opf == OPC_AND) || (iop == IOP_AND);
    wire op_or   = (opf == OPC_OR) || (iop == IOP_OR);
    wire op_xor  = (opf == OPC_XOR) || (iop == IOP_XOR);
    wire op_not  = (opf == OPC_NOT);
    wire op_neg  = (opf == OPC_NEG);
    wire op_shf  = (opf == OPC_SHF);
    wire op_cmp  = op_cmpb || op_cmpw;
    wire op_log  = op_and || op_or || op_xor || op_not;
    wire legal   = op_mul || op_div || op_cmp || op_log
                || op_neg || op_shf;

    // Register file reads combinationally in the request cycle
    assign DST_SEL = rn[SEL_W-1:0];
    assign SRC_SEL = rm[SEL_W-1:0];

    // Byte operands from the selected half of each 16-bit register
    wire [BYTE_W-1:0] d_b = get_byte(DST_VALUE, hi_d);
    wire [BYTE_W-1:0] s_b = is_imm ? imm : get_byte(SRC_VALUE, hi_s);

    // ==================================================================
    // Shift unit

    bal_shift_if shf ();

    assign shf.kind = bal_shk_t'(shk);
    assign shf.din  = d_b;
    assign shf.cin  = CARRY_IN;

    bal_shifter u_shifter
    (
        .sh (shf.unit)
    );

    // ==================================================================
    // Single-cycle arithmetic and logic

    wire [BYTE_W:0] cmpb_d = {1'b0, d_b} - {1'b0, s_b};
    wire [DATA_W:0] cmpw_d = {1'b0, DST_VALUE} - {1'b0, SRC_VALUE};
    wire [BYTE_W:0] neg_d  = {(BYTE_W+1){1'b0}} - {1'b0, d_b};
    wire [DATA_W-1:0] prod = {{BYTE_W{1'b0}}, DST_VALUE[BYTE_W-1:0]}
                           * {{BYTE_W{1'b0}}, s_b};

    wire [BYTE_W-1:0] log_r = op_and ? (d_b & s_b)
                            : op_or  ? (d_b | s_b)
                            : op_xor ? (d_b ^ s_b)
                            : ~d_b;
    wire [BYTE_W-1:0] byte_r = op_shf ? shf.dout
                             : op_neg ? neg_d[BYTE_W-1:0]
                             : log_r;

    // Byte results keep the other half of the register intact
    wire [DATA_W-1:0] one_data = op_mul ? prod
                               : put_byte(DST_VALUE, hi_d, byte_r);

    wire sub_v8  = (d_b[7] != s_b[7]) && (cmpb_d[7] != d_b[7]);
    wire sub_v16 = (DST_VALUE[15] != SRC_VALUE[15])
                && (cmpw_d[15] != DST_VALUE[15]);
    wire [BYTE_W-1:0] flg_b = op_cmpb ? cmpb_d[BYTE_W-1:0] : byte_r;

    wire one_z = op_cmpw ? (cmpw_d[DATA_W-1:0] == 16'h0000)
                         : (flg_b == 8'h00);
    wire one_n = op_cmpw ? cmpw_d[DATA_W-1] : flg_b[BYTE_W-1];
    wire one_c = op_shf  ? shf.cout
               : op_cmpw ? cmpw_d[DATA_W]
               : op_cmpb ? cmpb_d[BYTE_W]
               : op_neg  ? neg_d[BYTE_W]
               : CARRY_IN;
    wire one_v = op_cmpw ? sub_v16
               : op_cmpb ? sub_v8
               : op_neg  ? (d_b == 8'h80)
               : 1'b0;

    // ==================================================================
    // Handshake

    assign REQ_READY = (state_r == ST_IDLE);

    wire accept  = REQ_VALID && REQ_READY;
    wire one_go  = accept && !op_div;
    // Quotient must fit a byte, so the high byte must be below divisor
    wire div_ok  = (s_b != 8'h00) && (DST_VALUE[DATA_W-1:BYTE_W] < s_b);
    wire div_go  = accept && op_div && div_ok;
    wire div_bad = accept && op_div && !div_ok;

    // ==================================================================
    // Restoring divider, one quotient bit per cycle

    wire [BYTE_W:0]   dsh   = {rem_r, quo_r[BYTE_W-1]};
    wire              dge   = (dsh >= {1'b0, dvs_r});
    wire [BYTE_W:0]   dsub  = dsh - {1'b0, dvs_r};
    wire [BYTE_W-1:0] rem_s = dge ? dsub[BYTE_W-1:0] : dsh[BYTE_W-1:0];
    wire [BYTE_W-1:0] quo_s = {quo_r[BYTE_W-2:0], dge};
    wire              in_div   = (state_r == ST_DIV);
    wire              div_last = in_div && (cnt_r == CNT_LAST);

    assign state_nxt = div_go ? ST_DIV
                     : div_last ? ST_IDLE
                     : state_r;
    assign cnt_nxt = in_div ? cnt_r + CNT_ONE : {CNT_W{1'b0}};
    assign rem_nxt = div_go ? DST_VALUE[DATA_W-1:BYTE_W]
                   : in_div ? rem_s : rem_r;
    assign quo_nxt = div_go ? DST_VALUE[BYTE_W-1:0]
                   : in_div ? quo_s : quo_r;
    assign dvs_nxt = div_go ? s_b : dvs_r;

    // ==================================================================
    // Completion values

    wire              done_nxt = one_go || div_bad || div_last;
    wire              ill_nxt  = one_go && !legal;
    wire              wr_nxt   = div_last
                              || (one_go && legal && !op_cmp);
    wire [DATA_W-1:0] data_nxt = div_last ? {rem_s, quo_s}
                                          : one_data;
    wire              flwr_nxt = div_last || div_bad
                              || (one_go && legal && !op_mul);
    // Divide fault: flags only, the register is left alone
    wire fc_nxt = (div_last || div_bad) ? 1'b0 : one_c;
    wire fv_nxt = div_bad ? 1'b1 : div_last ? 1'b0 : one_v;
    wire fz_nxt = div_last ? (quo_s == 8'h00)
                : div_bad ? (s_b == 8'h00) : one_z;
    wire fn_nxt = div_last ? quo_s[BYTE_W-1]
                : div_bad ? 1'b0 : one_n;

    // ==================================================================
    // Registers

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 3'h0;
            rem_r   <= 8'h00;
            quo_r   <= 8'h00;
            dvs_r   <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            rem_r   <= rem_nxt;
            quo_r   <= quo_nxt;
            dvs_r   <= dvs_nxt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            done_r <= 1'b0;
            ill_r  <= 1'b0;
            wr_r   <= 1'b0;
            flwr_r <= 1'b0;
        end
        else
        begin
            done_r <= done_nxt;
            ill_r  <= ill_nxt;
            wr_r   <= wr_nxt;
            flwr_r <= flwr_nxt;
        end
    end

    // Destination index held through a divide
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
            wsel_r <= 3'h0;
        else if (accept)
            wsel_r <= rn[SEL_W-1:0];
    end

    // Result and flags hold until the next completion
    always_ff @(posedge CLK_SYS or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            data_r <= 16'h0000;
            fc_r   <= 1'b0;
            fv_r   <= 1'b0;
            fz_r   <= 1'b0;
            fn_r   <= 1'b0;
        end
        else if (done_nxt)
        begin
            data_r <= data_nxt;
            fc_r   <= fc_nxt;
            fv_r   <= fv_nxt;
            fz_r   <= fz_nxt;
            fn_r   <= fn_nxt;
        end
    end

    assign DONE    = done_r;
    assign ILLEGAL = ill_r;
    assign WB_EN   = wr_r;
    assign WB_SEL  = wsel_r;
    assign WB_DATA = data_r;
    assign FLAG_WR = flwr_r;
    assign FLAG_C  = fc_r;
    assign FLAG_V  = fv_r;
    assign FLAG_Z  = fz_r;
    assign FLAG_N  = fn_r;

    // ==================================================================
    // Checks

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);

    AST_MUL_PRODUCT:
    assert property (one_go && op_mul |=> WB_EN && WB_DATA ==
        {8'h00, $past(DST_VALUE[7:0])} * {8'h00, $past(s_b)})
        else $error("Multiply product wrong");

    AST_DIV_LATENCY:
    assert property (div_go |=> !DONE [*8] ##1 (DONE && WB_EN))
        else $error("Divide not done after nine cycles");

    AST_DIV_RESULT:
    assert property (div_go |-> ##9
        ({8'h00, WB_DATA[7:0]} * {8'h00, $past(s_b, 9)}
         + {8'h00, WB_DATA[15:8]} == $past(DST_VALUE, 9))
        && WB_DATA[15:8] < $past(s_b, 9))
        else $error("Divide quotient or remainder wrong");

    AST_CMP_NO_WRITE:
    assert property (one_go && op_cmp |=> DONE && FLAG_WR && !WB_EN)
        else $error("Compare wrote a register");

    AST_CMP_IMM_BYTE:
    assert property (one_go && iop == IOP_CMP |=>
        FLAG_Z == ($past(d_b) == $past(INSTR[7:0])))
        else $error("Immediate compare not byte wide");

    AST_CMP_WORD:
    assert property (one_go && op_cmpw |=>
        FLAG_Z == ($past(DST_VALUE) == $past(SRC_VALUE)))
        else $error("Word compare zero flag wrong");

    AST_NEG_VALUE:
    assert property (one_go && op_neg |=>
        get_byte(WB_DATA, $past(hi_d)) == 8'h00 - $past(d_b))
        else $error("Negate result wrong");

    AST_LOGIC_KEEPS:
    assert property (one_go && op_log |=>
        get_byte(WB_DATA, !$past(hi_d))
        == get_byte($past(DST_VALUE), !$past(hi_d)))
        else $error("Logic op touched other byte");

    AST_AND_VALUE:
    assert property (one_go && op_and |=> WB_EN &&
        get_byte(WB_DATA, $past(hi_d)) == ($past(d_b) & $past(s_b)))
        else $error("AND result wrong");

    AST_OR_VALUE:
    assert property (one_go && op_or |=>
        get_byte(WB_DATA, $past(hi_d)) == ($past(d_b) | $past(s_b)))
        else $error("OR result wrong");

    AST_XOR_VALUE:
    assert property (one_go && op_xor |=>
        get_byte(WB_DATA, $past(hi_d)) == ($past(d_b) ^ $past(s_b)))
        else $error("XOR result wrong");

    AST_NOT_VALUE:
    assert property (one_go && op_not |=>
        get_byte(WB_DATA, $past(hi_d)) == ~$past(d_b))
        else $error("Complement result wrong");

    AST_ASR_SIGN:
    assert property (one_go && op_shf && shk == SHK_ASR |=>
        get_byte(WB_DATA, $past(hi_d))
        == {$past(d_b[7]), $past(d_b[7:1])}
        && FLAG_C == $past(d_b[0]))
        else $error("Arithmetic right shift wrong");

    AST_LSR_ZERO:
    assert property (one_go && op_shf && shk == SHK_LSR |=>
        get_byte(WB_DATA, $past(hi_d)) == {1'b0, $past(d_b[7:1])})
        else $error("Logical right shift not zero filled");

    AST_RCL_CARRY:
    assert property (one_go && op_shf && shk == SHK_RCL |=>
        get_byte(WB_DATA, $past(hi_d))
        == {$past(d_b[6:0]), $past(CARRY_IN)}
        && FLAG_C == $past(d_b[7]))
        else $error("Rotate through carry wrong");

    AST_IMM_DEST:
    assert property (one_go && is_imm |=> WB_SEL == $past(INSTR[10:8]))
        else $error("Immediate form destination wrong");

endmodule
`default_nettype wire

/* File: src/bal_pkg.sv */
`default_nettype none
package bal_pkg;

    // ==================================================================
    // Widths
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SEL_W  = 3;
    localparam int FLD_W  = 4;
    localparam int OPF_W  = 8;
    localparam int IOP_W  = 4;
    localparam int SHK_W  = 3;

    // ==================================================================
    // Instruction field positions
    localparam int OPF_LSB = 8;
    localparam int IOP_LSB = 12;
    localparam int IRN_LSB = 8;
    localparam int RM_LSB  = 4;
    localparam int RN_LSB  = 0;
    localparam int SHK_LSB = 4;
    localparam int HIB_POS = 3;

    // ==================================================================
    // Register-form operation codes
    localparam logic [OPF_W-1:0] OPC_MUL  = 8'h40;
    localparam logic [OPF_W-1:0] OPC_DIV  = 8'h41;
    localparam logic [OPF_W-1:0] OPC_CMPB = 8'h42;
    localparam logic [OPF_W-1:0] OPC_CMPW = 8'h43;
    localparam logic [OPF_W-1:0] OPC_AND  = 8'h44;
    localparam logic [OPF_W-1:0] OPC_OR   = 8'h45;
    localparam logic [OPF_W-1:0] OPC_XOR  = 8'h46;
    localparam logic [OPF_W-1:0] OPC_NOT  = 8'h47;
    localparam logic [OPF_W-1:0] OPC_NEG  = 8'h48;
    localparam logic [OPF_W-1:0] OPC_SHF  = 8'h49;

    // ==================================================================
    // Immediate-form operation codes, upper nibble
    localparam logic [IOP_W-1:0] IOP_CMP = 4'hB;
    localparam logic [IOP_W-1:0] IOP_AND = 4'hC;
    localparam logic [IOP_W-1:0] IOP_OR  = 4'hD;
    localparam logic [IOP_W-1:0] IOP_XOR = 4'hE;

    // ==================================================================
    // Divider timing
    localparam int                CNT_W    = 3;
    localparam logic [CNT_W-1:0]  CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 3'h1;

    typedef enum logic [2:0] {
        SHK_ASL = 3'b000,
        SHK_ASR = 3'b001,
        SHK_LSL = 3'b010,
        SHK_LSR = 3'b011,
        SHK_ROL = 3'b100,
        SHK_ROR = 3'b101,
        SHK_RCL = 3'b110,
        SHK_RCR = 3'b111
    } bal_shk_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DIV  = 1'b1
    } bal_state_t;

endpackage
`default_nettype wire

/* File: src/bal_shift_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bal_shift_if;
    import bal_pkg::*;
    bal_shk_t          kind;
    logic [BYTE_W-1:0] din;
    logic              cin;
    logic [BYTE_W-1:0] dout;
    logic              cout;
    modport alu  (output kind, din, cin, input dout, cout);
    modport unit (input kind, din, cin, output dout, cout);
endinterface
`default_nettype wire

/* File: src/bal_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
module bal_shifter
(
    bal_shift_if.unit sh
);
    import bal_pkg::*;

    // ==================================================================
    // One-bit shift and rotate, carry out on top
    logic [BYTE_W:0] res;
    wire  [BYTE_W-1:0] d = sh.din;

    always_comb
    begin
        unique case (sh.kind)
            SHK_ASL: res = {d, 1'b0};
            SHK_ASR: res = {d[0], d[7], d[7:1]};
            SHK_LSL: res = {d, 1'b0};
            SHK_LSR: res = {d[0], 1'b0, d[7:1]};
            SHK_ROL: res = {d[7], d[6:0], d[7]};
            SHK_ROR: res = {d[0], d[0], d[7:1]};
            SHK_RCL: res = {d[7], d[6:0], sh.cin};
            SHK_RCR: res = {d[0], sh.cin, d[7:1]};
        endcase
    end

    // Bit shifted out always lands in carry
    assign sh.dout = res[BYTE_W-1:0];
    assign sh.cout = res[BYTE_W];

endmodule
`default_nettype wire

/* File: verif/bal_regs_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bal_regs_model
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [2:0]  dsel,
    input  wire logic [2:0]  ssel,
    output      logic [15:0] dval,
    output      logic [15:0] sval,
    output      logic        cy,
    input  wire logic        wb_en,
    input  wire logic [2:0]  wb_sel,
    input  wire logic [15:0] wb_data,
    input  wire logic        fl_wr,
    input  wire logic        fl_c,
    input  wire logic        ld_en,
    input  wire logic [2:0]  ld_sel,
    input  wire logic [15:0] ld_val,
    input  wire logic        ld_cy
);
    // ==================================================================
    // Register file
    // Whole words only; the block must merge byte results itself
    logic [15:0] regs [8];
    assign dval = regs[dsel];
    assign sval = regs[ssel];
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 8; i++)
                regs[i] <= 16'h0000;
            cy <= 1'b0;
        end
        else if (ld_en)
        begin
            regs[ld_sel] <= ld_val;
            cy <= ld_cy;
        end
        else
        begin
            if (wb_en)
                regs[wb_sel] <= wb_data;
            if (fl_wr)
                cy <= fl_c;
        end
    end
endmodule
`default_nettype wire

/* File: verif/byte_alu_arith_logic_shift_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module byte_alu_arith_logic_shift_tb;
    import bal_pkg::*;
    logic        clk_sys, arst_n, req_valid, req_ready, carry_in;
    logic [15:0] instr, dst_value, src_value, wb_data, ld_val;
    logic [2:0]  dst_sel, src_sel, wb_sel, ld_sel;
    logic        done, illegal, wb_en, flag_wr, flag_c, ld_en, ld_cy;
    int          n_mismatch = 0;
    int          checks_done = 0;

    // ==================================================================
    // Block and far side
    bal_alu bal_alu_inst (.CLK_SYS(clk_sys), .ARST_N(arst_n),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .INSTR(instr),
        .DST_SEL(dst_sel), .SRC_SEL(src_sel), .DST_VALUE(dst_value),
        .SRC_VALUE(src_value), .CARRY_IN(carry_in), .DONE(done),
        .ILLEGAL(illegal), .WB_EN(wb_en), .WB_SEL(wb_sel),
        .WB_DATA(wb_data), .FLAG_WR(flag_wr), .FLAG_C(flag_c),
        .FLAG_V(), .FLAG_Z(), .FLAG_N());
    bal_regs_model bal_regs_model_inst (.clk(clk_sys), .arst_n(arst_n),
        .dsel(dst_sel), .ssel(src_sel), .dval(dst_value),
        .sval(src_value), .cy(carry_in), .wb_en(wb_en), .wb_sel(wb_sel),
        .wb_data(wb_data), .fl_wr(flag_wr), .fl_c(flag_c),
        .ld_en(ld_en), .ld_sel(ld_sel), .ld_val(ld_val), .ld_cy(ld_cy));

    always #5 clk_sys = ~clk_sys;

    // ==================================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [15:0] e, v);
        checks_done++;
        if (e !== v)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, v);
        end
    endtask

    // Loads both operands, issues one request, judges the answer
    task automatic run(input logic [15:0] ins, input logic [2:0] di, si,
        input logic [15:0] d, s, input logic c, we, il,
        input logic [15:0] ed, input logic ec, input int lat);
        int n;
        @(negedge clk_sys);
        ld_en = 1'b1; ld_sel = si; ld_val = s; ld_cy = c;
        @(negedge clk_sys);
        ld_sel = di; ld_val = d;
        @(negedge clk_sys);
        ld_en = 1'b0; req_valid = 1'b1; instr = ins;
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk("latency", lat[15:0], n[15:0]);
        chk("illegal", {15'h0, il}, {15'h0, illegal});
        chk("wb_en", {15'h0, we}, {15'h0, wb_en});
        if (we)
            chk("wb_data", ed, wb_data);
        if (we)
            chk("wb_sel", {13'h0, di}, {13'h0, wb_sel});
        if (flag_wr === 1'b1)
            chk("flag_c", {15'h0, ec}, {15'h0, flag_c});
    endtask

    // ==================================================================
    // Scenarios
    task automatic t_mul;
        run(16'h4012, 2, 1, 16'h12FF, 16'h00FE, 0, 1, 0, 16'hFD02, 0, 1);
        run(16'h4092, 2, 1, 16'h7705, 16'h0300, 0, 1, 0, 16'h000F, 0, 1);
    endtask

    task automatic t_div;
        run(16'h4112, 2, 1, 16'h55FF, 16'h0056, 1, 1, 0, 16'h55FF, 0, 9);
        run(16'h4112, 2, 1, 16'h1234, 16'h0056, 0, 1, 0, 16'h1036, 0, 9);
        run(16'h4112, 2, 1, 16'h5600, 16'h0056, 1, 0, 0, 16'h0, 0, 1);
        run(16'h4112, 2, 1, 16'h0012, 16'h0000, 1, 0, 0, 16'h0, 0, 1);
    endtask

    task automatic t_cmp;
        run(16'h4212, 2, 1, 16'h0010, 16'h0020, 0, 0, 0, 16'h0, 1, 1);
        run(16'hB205, 2, 0, 16'h0010, 16'h0000, 1, 0, 0, 16'h0, 0, 1);
        run(16'h4312, 2, 1, 16'h0100, 16'h00FF, 1, 0, 0, 16'h0, 0, 1);
    endtask

    task automatic t_neg;
        run(16'h4802, 2, 0, 16'hAB01, 16'h0000, 0, 1, 0, 16'hABFF, 1, 1);
    endtask

    task automatic t_logic;
        run(16'h4413, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5A30, 1, 1);
        run(16'h441B, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h18F0, 1, 1);
        run(16'h4513, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5AFC, 1, 1);
        run(16'h4613, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5ACC, 1, 1);
        run(16'h4703, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5A0F, 1, 1);
        run(16'hC30F, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5A00, 1, 1);
        run(16'hD30F, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5AFF, 1, 1);
        run(16'hE3FF, 3, 1, 16'h5AF0, 16'h003C, 1, 1, 0, 16'h5A0F, 1, 1);
    endtask

    // Carry in set, so left rotate and left rotate-through agree here
    task automatic t_shift;
        logic [7:0] sr [8] = '{8'h28, 8'hCA, 8'h28, 8'h4A,
                               8'h29, 8'h4A, 8'h29, 8'hCA};
        for (int k = 0; k < 8; k++)
            run({8'h49, 1'b0, k[2:0], 4'h2}, 2, 0, 16'h7794, 16'h0, 1, 1,
                0, {8'h77, sr[k]}, ~k[0], 1);
        run(16'h4962, 2, 0, 16'h7794, 16'h0, 0, 1, 0, 16'h7728, 1, 1);
        run(16'h4972, 2, 0, 16'h7794, 16'h0, 0, 1, 0, 16'h774A, 0, 1);
    endtask

    task automatic t_illegal;
        run(16'h4A12, 2, 1, 16'h1111, 16'h2222, 0, 0, 1, 16'h0, 0, 1);
        run(16'h8205, 2, 1, 16'h1111, 16'h2222, 0, 0, 1, 16'h0, 0, 1);
    endtask

    // ==================================================================
    // Verdict
    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #60000;
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        clk_sys = 1'b0; arst_n = 1'b0; req_valid = 1'b0; instr = 16'h0;
        ld_en = 1'b0; ld_sel = 3'h0; ld_val = 16'h0; ld_cy = 1'b0;
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        t_mul;
        t_div;
        t_cmp;
        t_neg;
        t_logic;
        t_shift;
        t_illegal;
        finish_test;
    end
endmodule
`default_nettype wire
